// [core/usf_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 125 MHz system clock, 12-bit byte address
// Notes: Included by the serial port top level and its testbench
`ifndef USF_CFG_SVH
`define USF_CFG_SVH
`define USF_OFF_DATA 12'h000
`define USF_OFF_RSR 12'h004
`define USF_OFF_FLAG 12'h018
`define USF_OFF_ILPR 12'h020
`define USF_OFF_IBRD 12'h024
`define USF_OFF_FBRD 12'h028
`define USF_OFF_LCRH 12'h02C
`define USF_OFF_CTL 12'h030
`define USF_OFF_IFLS 12'h034
`define USF_OFF_IM 12'h038
`define USF_OFF_RIS 12'h03C
`define USF_OFF_MIS 12'h040
`define USF_OFF_ICR 12'h044
// Port control fields
`define USF_CTL_EN 0
`define USF_CTL_SIR 1
`define USF_CTL_SIRLP 2
`define USF_CTL_LBE 7
`define USF_CTL_TXE 8
`define USF_CTL_RXE 9
`define USF_CTL_RST 10'h300
// Line control fields
`define USF_LC_PEN 1
`define USF_LC_EPS 2
`define USF_LC_STP2 3
`define USF_LC_FEN 4
// Level select fields
`define USF_IFLS_TX 0
`define USF_IFLS_RX 3
`define USF_IFLS_RST 6'h12
// Event bits
`define USF_EV_RX 4
`define USF_EV_TX 5
`define USF_EV_RT 6
`define USF_EV_FE 7
`define USF_EV_PE 8
`define USF_EV_BE 9
`define USF_EV_OE 10
// Timing
`define USF_CLK_HZ 125000000
`define USF_LP_REF_HZ 1843200
`define USF_LP_DIV (`USF_CLK_HZ / `USF_LP_REF_HZ)
`define USF_IR_PULSE 3
`define USF_RT_BITS 32
`define USF_RT_TICKS (`USF_RT_BITS * 16)
`endif

// [core/usf_pkg.sv]
// Purpose: Types shared by the serial port modules
// Assumes: Nothing
// Notes: State enums for transmitter and receiver
package usf_pkg;
  typedef enum logic [2:0] {
    USF_TX_IDLE, USF_TX_START, USF_TX_DATA, USF_TX_PAR, USF_TX_STOP
  } usf_tx_e;
  typedef enum logic [2:0] {
    USF_RX_IDLE, USF_RX_START, USF_RX_DATA, USF_RX_PAR, USF_RX_STOP,
    USF_RX_WAIT
  } usf_rx_e;
endpackage : usf_pkg

// [core/usf_fifo_if.sv]
// Purpose: Connection between port logic and one FIFO
// Assumes: Single clock
// Notes: Shallow selects single-entry holding mode
`timescale 1ns/1ps
interface usf_fifo_if #(parameter int W = 8, parameter int AW = 4);
  logic push;
  logic pop;
  logic shallow;
  logic full;
  logic empty;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [AW:0] count;
  modport owner(output push, pop, shallow, wdata,
                input rdata, full, empty, count);
  modport store(input push, pop, shallow, wdata,
                output rdata, full, empty, count);
endinterface : usf_fifo_if

// [core/usf_fifo.sv]
// Purpose: FIFO with single-entry holding mode
// Assumes: Push when full and pop when empty are dropped
// Notes: Read data shows the oldest entry
`timescale 1ns/1ps
module usf_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Owner side
  usf_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  if ((1 << AW) != DEPTH || DEPTH < 8) begin : g_chk
    $error("usf_fifo: DEPTH must be a power of two, at least 8");
  end

  assign f.full = f.shallow ? (cnt_q != '0) : (cnt_q == (AW+1)'(DEPTH));
  assign f.empty = (cnt_q == '0);
  assign f.count = cnt_q;
  assign f.rdata = mem_q[rp_q];
  assign do_push = f.push && !f.full;
  assign do_pop = f.pop && !f.empty;

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem_q[wp_q] <= f.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk_in) disable iff (reset_in)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : usf_fifo

// [core/usf_top.sv]
// Purpose: Serial port with infrared codec, FIFOs and event logic
// Assumes: Registers on a plain strobe port, read data one cycle later
// Notes: Byte offsets, unmapped reads return zero
`timescale 1ns/1ps
`include "usf_cfg.svh"

module usf_top import usf_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int RT_TICKS = `USF_RT_TICKS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Serial pins
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  // Interrupt request
  output logic irq_out
);
  localparam int CW = $clog2(DEPTH) + 1;

  if (RT_TICKS < 2 || RT_TICKS > 1023) begin : g_chk
    $error("usf_top: RT_TICKS out of range");
  end

  usf_fifo_if #(.W(8), .AW(CW-1)) txf ();
  usf_fifo_if #(.W(12), .AW(CW-1)) rxf ();

  logic [9:0] ctl_q;
  logic [15:0] ibrd_q;
  logic [5:0] fbrd_q;
  logic [7:0] ilpr_q;
  logic [5:0] ifls_q;
  logic [10:0] im_q;
  logic [10:0] ris_q;
  logic [10:0] ris_d;
  logic [10:0] ev_set;
  logic [10:0] ev_clr;
  logic [3:0] rsr_q;
  logic [29:0] commit_q;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  logic irq_q;
  logic pin_q;
  logic wr_data, wr_rsr, wr_lcrh, wr_icr, rd_data;
  logic en, siren, sirlp, loopback_bit, txe, rxe, fifo_enable_bit, pen, eps, stp2;
  logic [15:0] bcnt_q;
  logic [5:0] facc_q;
  logic [6:0] fsum;
  logic oversample_tick;
  logic [7:0] lpcnt_q;
  logic [7:0] lp_div;
  logic lowpower_ir_ref_tick;
  logic lp_go;
  usf_tx_e tx_st_q;
  logic [3:0] tx_sub_q;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_n_q;
  logic tx_par_q, tx_stop_q, tx_load, tx_end, tx_bit;
  logic [1:0] ir_lp_q;
  logic ir_norm, ir_bit;
  logic rx_s1_q, rx_s2_q;
  logic [4:0] dec_q;
  logic rx_line;
  usf_rx_e rx_st_q;
  logic [3:0] rx_sub_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_n_q;
  logic rx_pb_q, rx_push_q, oe_pend_q, rx_end, rx_brk, rx_pe;
  logic [10:0] rx_ent_q;
  logic [CW-1:0] rx_cnt_q, tx_cnt_q, rx_lvl, tx_lvl;
  logic tx_empty_q;
  logic [9:0] rt_q;
  logic rt_hit;

  function automatic logic [CW-1:0] lvl_of(input logic [2:0] s);
    logic [CW-1:0] e;
    e = CW'(DEPTH / 8);
    case (s)
      3'h0: lvl_of = e;
      3'h1: lvl_of = CW'(e * 2);
      3'h3: lvl_of = CW'(e * 6);
      3'h4: lvl_of = CW'(e * 7);
      default: lvl_of = CW'(e * 4);
    endcase
  endfunction : lvl_of

  assign en = ctl_q[`USF_CTL_EN];
  assign siren = ctl_q[`USF_CTL_SIR];
  assign sirlp = ctl_q[`USF_CTL_SIRLP];
  assign loopback_bit = ctl_q[`USF_CTL_LBE];
  assign txe = ctl_q[`USF_CTL_TXE];
  assign rxe = ctl_q[`USF_CTL_RXE];
  assign fifo_enable_bit = commit_q[`USF_LC_FEN];
  assign pen = commit_q[`USF_LC_PEN];
  assign eps = commit_q[`USF_LC_EPS];
  assign stp2 = commit_q[`USF_LC_STP2];
  assign wr_data = wr_in && addr_in == `USF_OFF_DATA;
  assign wr_rsr = wr_in && addr_in == `USF_OFF_RSR;
  assign wr_lcrh = wr_in && addr_in == `USF_OFF_LCRH;
  assign wr_icr = wr_in && addr_in == `USF_OFF_ICR;
  assign rd_data = rd_in && addr_in == `USF_OFF_DATA;
  assign rdata_out = rdata_q;
  assign irq_out = irq_q;
  assign serial_out_pin_out = pin_q;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctl_q <= `USF_CTL_RST;
      ibrd_q <= 16'h0000;
      fbrd_q <= 6'h00;
      ilpr_q <= 8'h00;
      ifls_q <= `USF_IFLS_RST;
      im_q <= 11'h000;
    end else if (wr_in) begin
      case (addr_in)
        `USF_OFF_CTL: ctl_q <= wdata_in[9:0];
        `USF_OFF_IBRD: ibrd_q <= wdata_in[15:0];
        `USF_OFF_FBRD: fbrd_q <= wdata_in[5:0];
        `USF_OFF_ILPR: ilpr_q <= wdata_in[7:0];
        `USF_OFF_IFLS: ifls_q <= wdata_in[5:0];
        `USF_OFF_IM: im_q <= wdata_in[10:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      commit_q <= 30'h0000_0000;
    end else if (wr_lcrh) begin
      commit_q <= {ibrd_q, fbrd_q, wdata_in[7:0]};
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_in)
      `USF_OFF_DATA: rd_mux[11:0] = rxf.rdata;
      `USF_OFF_RSR: rd_mux[3:0] = rsr_q;
      `USF_OFF_FLAG: rd_mux[7:3] = {txf.empty, rxf.full, txf.full,
        rxf.empty, !txf.empty || tx_st_q != USF_TX_IDLE};
      `USF_OFF_ILPR: rd_mux[7:0] = ilpr_q;
      `USF_OFF_IBRD: rd_mux[15:0] = ibrd_q;
      `USF_OFF_FBRD: rd_mux[5:0] = fbrd_q;
      `USF_OFF_LCRH: rd_mux[7:0] = commit_q[7:0];
      `USF_OFF_CTL: rd_mux[9:0] = ctl_q;
      `USF_OFF_IFLS: rd_mux[5:0] = ifls_q;
      `USF_OFF_IM: rd_mux[10:0] = im_q;
      `USF_OFF_RIS: rd_mux[10:0] = ris_q;
      `USF_OFF_MIS: rd_mux[10:0] = ris_q & im_q;
      default: ;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud and low-power references
  assign fsum = {1'b0, facc_q} + {1'b0, commit_q[13:8]};

  always_ff @(posedge clk_in) begin
    if (reset_in || !en) begin
      bcnt_q <= 16'h0000;
      facc_q <= 6'h00;
      oversample_tick <= 1'b0;
    end else begin
      oversample_tick <= 1'b0;
      if (commit_q[29:14] != 16'h0000) begin
        if (bcnt_q == 16'h0000) begin
          oversample_tick <= 1'b1;
          facc_q <= fsum[5:0];
          bcnt_q <= commit_q[29:14] - 16'h0001 + 16'(fsum[6]);
        end else begin
          bcnt_q <= bcnt_q - 16'h0001;
        end
      end
    end
  end

  assign lp_div = (ilpr_q == 8'h00) ? 8'(`USF_LP_DIV) : ilpr_q;

  assign lowpower_ir_ref_tick = lpcnt_q >= lp_div - 8'h01;
  assign lp_go = oversample_tick && tx_sub_q == 4'h0 &&
    tx_st_q != USF_TX_IDLE && !tx_bit;

  // Restart with each pulse so it spans whole reference periods
  always_ff @(posedge clk_in) begin
    if (reset_in || lp_go || lowpower_ir_ref_tick) begin
      lpcnt_q <= 8'h00;
    end else begin
      lpcnt_q <= lpcnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  assign tx_load = tx_st_q == USF_TX_IDLE && en && txe && !txf.empty &&
    oversample_tick;
  assign tx_end = oversample_tick && tx_sub_q == 4'hF;
  assign txf.pop = tx_load;
  assign txf.push = wr_data;
  assign txf.wdata = wdata_in[7:0];
  assign txf.shallow = !fifo_enable_bit;

  always_comb begin
    tx_bit = 1'b1;
    unique case (tx_st_q)
      USF_TX_START: tx_bit = 1'b0;
      USF_TX_DATA: tx_bit = tx_sh_q[0];
      USF_TX_PAR: tx_bit = tx_par_q;
      USF_TX_IDLE, USF_TX_STOP: tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_st_q <= USF_TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_sh_q <= 8'h00;
      tx_n_q <= 3'h0;
      tx_par_q <= 1'b0;
      tx_stop_q <= 1'b0;
    end else begin
      if (oversample_tick) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
      unique case (tx_st_q)
        USF_TX_IDLE: begin
          tx_sub_q <= 4'h0;
          if (tx_load) begin
            tx_st_q <= USF_TX_START;
            tx_sh_q <= txf.rdata;
            tx_par_q <= ^txf.rdata ^ !eps;
            tx_n_q <= 3'h0;
            tx_stop_q <= 1'b0;
          end
        end
        USF_TX_START: if (tx_end) tx_st_q <= USF_TX_DATA;
        USF_TX_DATA: begin
          if (tx_end) begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_n_q <= tx_n_q + 3'h1;
            if (tx_n_q == 3'h7) begin
              tx_st_q <= pen ? USF_TX_PAR : USF_TX_STOP;
            end
          end
        end
        USF_TX_PAR: if (tx_end) tx_st_q <= USF_TX_STOP;
        USF_TX_STOP: begin
          if (tx_end) begin
            if (stp2 && !tx_stop_q) begin
              tx_stop_q <= 1'b1;
            end else begin
              tx_st_q <= USF_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Infrared encoder and pin
  assign ir_norm = tx_st_q != USF_TX_IDLE && !tx_bit &&
    tx_sub_q < 4'(`USF_IR_PULSE);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ir_lp_q <= 2'h0;
    end else if (lp_go) begin
      ir_lp_q <= 2'(`USF_IR_PULSE);
    end else if (lowpower_ir_ref_tick && ir_lp_q != 2'h0) begin
      ir_lp_q <= ir_lp_q - 2'h1;
    end
  end

  assign ir_bit = sirlp ? (ir_lp_q != 2'h0) : ir_norm;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= siren ? ir_bit : tx_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive front end and decoder
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_in_pin_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Stretch each low pulse over one bit period
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dec_q <= 5'h00;
    end else if (!rx_s2_q) begin
      dec_q <= 5'h10;
    end else if (oversample_tick && dec_q != 5'h00) begin
      dec_q <= dec_q - 5'h01;
    end
  end

  always_comb begin
    if (loopback_bit) begin
      rx_line = tx_bit;
    end else if (siren) begin
      rx_line = (tx_st_q != USF_TX_IDLE) || (rx_s2_q && dec_q == 5'h00);
    end else begin
      rx_line = rx_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  assign rx_end = oversample_tick && rx_sub_q == 4'hF;
  assign rx_brk = rx_sh_q == 8'h00 && !rx_line && (!pen || !rx_pb_q);
  assign rx_pe = pen && (rx_pb_q != (^rx_sh_q ^ !eps));
  assign rxf.push = rx_push_q;
  assign rxf.wdata = {oe_pend_q, rx_ent_q};
  assign rxf.pop = rd_data;
  assign rxf.shallow = !fifo_enable_bit;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_st_q <= USF_RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_n_q <= 3'h0;
      rx_pb_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_ent_q <= 11'h000;
    end else begin
      rx_push_q <= 1'b0;
      if (oversample_tick) begin
        rx_sub_q <= rx_sub_q + 4'h1;
      end
      unique case (rx_st_q)
        USF_RX_IDLE: begin
          rx_sub_q <= 4'h0;
          if (!rx_line && en && rxe) rx_st_q <= USF_RX_START;
        end
        USF_RX_START: begin
          if (oversample_tick && rx_sub_q == 4'h7) begin
            rx_sub_q <= 4'h0;
            rx_n_q <= 3'h0;
            rx_pb_q <= 1'b0;
            rx_st_q <= rx_line ? USF_RX_IDLE : USF_RX_DATA;
          end
        end
        USF_RX_DATA: begin
          if (rx_end) begin
            rx_sh_q <= {rx_line, rx_sh_q[7:1]};
            rx_n_q <= rx_n_q + 3'h1;
            if (rx_n_q == 3'h7) begin
              rx_st_q <= pen ? USF_RX_PAR : USF_RX_STOP;
            end
          end
        end
        USF_RX_PAR: begin
          if (rx_end) begin
            rx_pb_q <= rx_line;
            rx_st_q <= USF_RX_STOP;
          end
        end
        USF_RX_STOP: begin
          if (rx_end) begin
            rx_push_q <= 1'b1;
            rx_ent_q <= {rx_brk, rx_pe, !rx_line, rx_sh_q};
            rx_st_q <= rx_brk ? USF_RX_WAIT : USF_RX_IDLE;
          end
        end
        USF_RX_WAIT: if (rx_line) rx_st_q <= USF_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      oe_pend_q <= 1'b0;
    end else if (rx_push_q) begin
      oe_pend_q <= rxf.full;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rsr_q <= 4'h0;
    end else begin
      if (wr_rsr) rsr_q <= 4'h0;
      if (rd_data && !rxf.empty) rsr_q <= rxf.rdata[11:8];
      if (rx_push_q && rxf.full) rsr_q[3] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events and interrupt
  assign rx_lvl = lvl_of(ifls_q[`USF_IFLS_RX+:3]);
  assign tx_lvl = lvl_of(ifls_q[`USF_IFLS_TX+:3]);
  assign rt_hit = oversample_tick && rt_q == 10'(RT_TICKS - 1);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_cnt_q <= '0;
      tx_cnt_q <= '0;
      tx_empty_q <= 1'b0;
    end else begin
      rx_cnt_q <= rxf.count;
      tx_cnt_q <= txf.count;
      tx_empty_q <= txf.empty;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in || rxf.empty || rx_push_q || rd_data) begin
      rt_q <= 10'h000;
    end else if (oversample_tick && rt_q != 10'(RT_TICKS)) begin
      rt_q <= rt_q + 10'h001;
    end
  end

  always_comb begin
    ev_set = 11'h000;
    ev_clr = 11'h000;
    if (wr_icr) ev_clr = wdata_in[10:0];
    if (fifo_enable_bit) begin
      ev_set[`USF_EV_RX] = rx_cnt_q < rx_lvl && rxf.count >= rx_lvl;
      if (rxf.count < rx_lvl) ev_clr[`USF_EV_RX] = 1'b1;
      ev_set[`USF_EV_TX] = tx_cnt_q > tx_lvl && txf.count <= tx_lvl;
      if (txf.count > tx_lvl) ev_clr[`USF_EV_TX] = 1'b1;
    end else begin
      ev_set[`USF_EV_RX] = rx_push_q && !rxf.full;
      if (rd_data) ev_clr[`USF_EV_RX] = 1'b1;
      ev_set[`USF_EV_TX] = txf.empty && !tx_empty_q;
      if (wr_data) ev_clr[`USF_EV_TX] = 1'b1;
    end
    ev_set[`USF_EV_RT] = rt_hit;
    if (rd_data) ev_clr[`USF_EV_RT] = 1'b1;
    ev_set[`USF_EV_FE] = rx_push_q && rx_ent_q[8];
    ev_set[`USF_EV_PE] = rx_push_q && rx_ent_q[9];
    ev_set[`USF_EV_BE] = rx_push_q && rx_ent_q[10];
    ev_set[`USF_EV_OE] = rx_push_q && rxf.full;
    ris_d = (ris_q & ~ev_clr) | ev_set;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ris_q <= 11'h000;
      irq_q <= 1'b0;
    end else begin
      ris_q <= ris_d;
      irq_q <= |(ris_q & im_q);
    end
  end

  usf_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
    .clk_in(clk_in), .reset_in(reset_in), .f(txf));
  usf_fifo #(.W(12), .DEPTH(DEPTH)) u_rxf (
    .clk_in(clk_in), .reset_in(reset_in), .f(rxf));

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence tx_start_s;
    ##1 (tx_st_q == USF_TX_START && tx_sub_q == 4'h0);
  endsequence

  sequence start_end_s;
    tx_st_q == USF_TX_START && tx_end;
  endsequence

  irq_or_a: assert property (|(ris_q & im_q) |=> irq_out)
    else $error("enabled event not on irq");
  irq_mask_a: assert property (!(|(ris_q & im_q)) |=> !irq_out)
    else $error("irq without enabled event");
  icr_clear_a: assert property (wr_icr && wdata_in[`USF_EV_OE] &&
    !(rx_push_q && rxf.full) |=> !ris_q[`USF_EV_OE])
    else $error("clear did not drop event");
  commit_hold_a: assert property (!wr_lcrh |=> $stable(commit_q))
    else $error("divisor changed without commit");
  shallow_fifo_a: assert property (!fifo_enable_bit |-> rxf.count <= CW'(1))
    else $error("holding mode deeper than one");
  overrun_flag_a: assert property (rx_push_q && rxf.full |=>
    rsr_q[3] && ris_q[`USF_EV_OE]) else $error("overrun not flagged");
  half_duplex_a: assert property (siren && !loopback_bit &&
    tx_st_q != USF_TX_IDLE && rx_st_q == USF_RX_IDLE |=>
    rx_st_q == USF_RX_IDLE) else $error("rx open during tx");
  loopback_a: assert property (loopback_bit && en && rxe && !tx_bit &&
    rx_st_q == USF_RX_IDLE |=> rx_st_q == USF_RX_START)
    else $error("loopback path broken");
  ir_pulse_a: assert property (siren && !sirlp &&
    tx_st_q == USF_TX_START && tx_sub_q < 4'h3 |=> serial_out_pin_out)
    else $error("ir pulse missing");
  ir_one_a: assert property (siren && !sirlp &&
    tx_st_q == USF_TX_STOP |=> !serial_out_pin_out)
    else $error("ir one not low");
  tx_start_a: assert property (tx_load |-> tx_start_s)
    else $error("start bit not entered");
  bit_period_a: assert property (start_end_s |=>
    tx_st_q == USF_TX_DATA) else $error("bit period wrong");
  level_reset_a: assert property (@(posedge clk_in) disable iff (1'b0)
    $past(reset_in) |-> ifls_q == `USF_IFLS_RST)
    else $error("trigger level reset wrong");
endmodule : usf_top

// [dv/usf_peer.sv]
// Purpose: Remote sender driving the receive pin
// Assumes: Line idles high, as if pulled up
// Notes: Infrared zero is a low pulse of 3/16 bit
`timescale 1ns/1ps
module usf_peer (
  // Clock
  input wire logic clk_in,
  // Line toward the port
  output logic line_out
);
  initial line_out = 1'b1;
  // Sends only when called, never during port transmit
  task automatic send(input logic [7:0] b, input bit ir, input int n);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < n; k++) begin
        @(posedge clk_in);
        line_out <= f[i] | (ir && k >= n * 3 / 16);
      end
    end
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask : send
endmodule : usf_peer

// [dv/test_uart_sir_fifo_irq.sv]
// Purpose: Self-checking bench for the serial port
// Assumes: 125 MHz clock, divisor 2, bit period 32 clocks
// Notes: Loopback and remote sender feed the receiver
`timescale 1ns/1ps
`include "usf_cfg.svh"
module test_uart_sir_fifo_irq;
  logic clk_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, pin;
  logic [11:0] addr_in = '0;
  logic [31:0] wdata_in = '0, rdata_out, v, seed = 32'h5f6a;
  logic serial_out_pin_out, irq_out;
  logic [7:0] q[$];
  int mismatches = 0, num_checks = 0;
  initial forever #4 clk_in = ~clk_in;
  usf_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .serial_in_pin_in(pin), .serial_out_pin_out(serial_out_pin_out),
    .irq_out(irq_out));
  usf_peer u_peer (.clk_in(clk_in), .line_out(pin));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
    chk(v & m, e);
  endtask : rdc
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk_in);
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [31:0] n, hi;
    logic last;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    rdc(`USF_OFF_IFLS, '1, 32'h12);
    rdc(`USF_OFF_FLAG, '1, 32'h90);
    rdc(`USF_OFF_RIS, '1, 32'h20);
    chk({31'h0, irq_out}, 32'h0);
    wr(`USF_OFF_IM, 32'h20);
    rdc(`USF_OFF_MIS, '1, 32'h20);
    chk({31'h0, irq_out}, 32'h1);
    wr(`USF_OFF_ICR, 32'h20);
    rdc(`USF_OFF_RIS, '1, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    // Holding mode through loopback
    wr(`USF_OFF_CTL, 32'h300);
    wr(`USF_OFF_IBRD, 32'h2);
    wr(`USF_OFF_FBRD, 32'h0);
    wr(`USF_OFF_LCRH, 32'h0);
    seed = lfsr(seed);
    wr(`USF_OFF_DATA, {24'h0, seed[7:0]});
    wr(`USF_OFF_CTL, 32'h381);
    repeat (400) @(posedge clk_in);
    rdc(`USF_OFF_RIS, 32'h30, 32'h30);
    rdc(`USF_OFF_DATA, '1, {24'h0, seed[7:0]});
    rdc(`USF_OFF_RIS, 32'h10, 32'h0);
    // FIFO mode: fill past full, then drain
    wr(`USF_OFF_CTL, 32'h300);
    wr(`USF_OFF_LCRH, 32'h10);
    for (int i = 0; i < 17; i++) begin
      seed = lfsr(seed);
      if (i < 16) q.push_back(seed[7:0]);
      wr(`USF_OFF_DATA, {24'h0, seed[7:0]});
    end
    rdc(`USF_OFF_FLAG, '1, 32'h38);
    rdc(`USF_OFF_RIS, 32'h20, 32'h0);
    wr(`USF_OFF_CTL, 32'h381);
    repeat (5600) @(posedge clk_in);
    rdc(`USF_OFF_FLAG, '1, 32'hc0);
    rdc(`USF_OFF_RIS, 32'h30, 32'h30);
    for (int i = 0; i < 16; i++) begin
      rdc(`USF_OFF_DATA, '1, {24'h0, q.pop_front()});
    end
    rdc(`USF_OFF_RIS, 32'h10, 32'h0);
    // Infrared transmit pulses, then receive
    for (int m = 0; m < 2; m++) begin
      wr(`USF_OFF_CTL, 32'h300);
      wr(`USF_OFF_ILPR, 32'h4);
      wr(`USF_OFF_CTL, m ? 32'h307 : 32'h303);
      seed = lfsr(seed);
      wr(`USF_OFF_DATA, {24'h0, seed[7:0]});
      n = 0;
      hi = 0;
      last = 1'b0;
      repeat (400) begin
        @(negedge clk_in);
        hi += serial_out_pin_out;
        n += serial_out_pin_out & !last;
        last = serial_out_pin_out;
      end
      chk(n, 9 - $countones(seed[7:0]));
      chk(hi, n * (m ? 12 : 6));
      // Scaled turnaround before receiving
      repeat (200) @(posedge clk_in);
      seed = lfsr(seed);
      u_peer.send(seed[7:0], 1'b1, 32);
      rdc(`USF_OFF_DATA, '1, {24'h0, seed[7:0]});
    end
    // Holding mode with parity: second char overruns, then timeout
    wr(`USF_OFF_CTL, 32'h300);
    wr(`USF_OFF_LCRH, 32'h0e);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      wr(`USF_OFF_DATA, {24'h0, seed[7:0]});
      wr(`USF_OFF_CTL, 32'h381);
      repeat (420) @(posedge clk_in);
    end
    rdc(`USF_OFF_RIS, 32'h410, 32'h410);
    rdc(`USF_OFF_RSR, '1, 32'h8);
    wr(`USF_OFF_ICR, 32'h400);
    rdc(`USF_OFF_RIS, 32'h400, 32'h0);
    repeat (1100) @(posedge clk_in);
    rdc(`USF_OFF_RIS, 32'h40, 32'h40);
    rdc(`USF_OFF_DATA, '1, {24'h0, q.pop_front()});
    report_and_stop();
  end
endmodule : test_uart_sir_fifo_irq
